// >>> hdl/ivwm_defines.svh
// Behaviour
// - The top-level request sits at IRQ 0, vector 0x8008, and never wakes the core from any low-power mode.
// - The flash done or protected-write request sits at IRQ 1, vector 0x800c, and wakes only from the Wait modes.
// - DMA channels 0 and 1 half and complete requests merge onto IRQ 2, vector 0x8010, waking only from Wait.
// - DMA channels 2 and 3 half and complete requests merge onto IRQ 3, vector 0x8014, waking only from Wait.
// - Clock alarm, periodic wakeup and three tamper requests merge onto IRQ 4, vector 0x8018, waking from all modes.
// - The port B pin request sits at IRQ 6, vector 0x8020, waking from all modes.
// - The port D pin request sits at IRQ 7, vector 0x8024, waking from all modes.
// - Converter end, watchdog and overrun requests merge onto IRQ 18, vector 0x8050, waking from all modes.
// - The top-level request is the OR of the second general timer and basic timer overflow requests.
// - In wait-for-event mode only an enabled request is served, and the core returns to that mode afterwards.
`ifndef IVWM_DEFINES_SVH
`define IVWM_DEFINES_SVH
`define IVWM_NUM_IRQ      19
`define IVWM_VEC_RESET    24'h008000
`define IVWM_VEC_TRAP     24'h008004
`define IVWM_VEC_BASE     24'h008008
`define IVWM_IRQ_TOP      5'h00
`define IVWM_IRQ_FLASH    5'h01
`define IVWM_IRQ_DMA01    5'h02
`define IVWM_IRQ_DMA23    5'h03
`define IVWM_IRQ_RTC      5'h04
`define IVWM_IRQ_VDET     5'h05
`define IVWM_IRQ_PORTB    5'h06
`define IVWM_IRQ_PORTD    5'h07
`define IVWM_IRQ_PIN0     5'h08
`define IVWM_IRQ_RSVD     5'h10
`define IVWM_IRQ_CLK      5'h11
`define IVWM_IRQ_ADC      5'h12
// Wake masks per IRQ, bit n = IRQ n
`define IVWM_WAKE_HALT    19'h04fff0
`define IVWM_WAKE_WAIT    19'h06fffe
`endif

// >>> hdl/ivwm_pkg.sv
package ivwm_pkg;
    typedef enum logic [2:0] {
        IVWM_RUN                     = 3'h0,
        IVWM_HALT                    = 3'h1,
        IVWM_ACTIVE_HALT             = 3'h3,
        IVWM_WAIT_FOR_INTERRUPT_MODE = 3'h2,
        IVWM_WAIT_FOR_EVENT_MODE     = 3'h6
    } ivwm_mode_type;
    typedef enum logic [1:0] {
        IVWM_IDLE  = 2'h0,
        IVWM_SERVE = 2'h1,
        IVWM_BACK  = 2'h3
    } ivwm_state_type;
endpackage

// >>> hdl/ivwm_wake_sel.sv
`include "ivwm_defines.svh"
module ivwm_wake_sel
    import ivwm_pkg::*;
(
    input  wire logic [18:0]    pend,
    input  wire ivwm_mode_type  mode,
    output logic      [18:0]    wake_ok
);
    always_comb begin
        case (mode)
            IVWM_HALT, IVWM_ACTIVE_HALT: wake_ok = pend & `IVWM_WAKE_HALT;
            IVWM_WAIT_FOR_INTERRUPT_MODE, IVWM_WAIT_FOR_EVENT_MODE: wake_ok = pend & `IVWM_WAKE_WAIT;
            default:                     wake_ok = pend;
        endcase
    end
endmodule

// >>> hdl/ivwm_top.sv
`include "ivwm_defines.svh"
module ivwm_top
    import ivwm_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire logic           tim2_ovf_req,
    input  wire logic           tim4_ovf_req,
    input  wire logic [1:0]     flash_req,
    input  wire logic [3:0]     dma01_req,
    input  wire logic [3:0]     dma23_req,
    input  wire logic [4:0]     rtc_req,
    input  wire logic           voltage_detector_request,
    input  wire logic           port_b_pin_request,
    input  wire logic           port_d_pin_request,
    input  wire logic [7:0]     pin_req,
    input  wire logic           clock_security_request,
    input  wire logic [2:0]     adc_req,
    input  wire logic [18:0]    irq_enable,
    input  wire ivwm_mode_type  core_mode,
    input  wire logic           irq_done,
    output logic      [18:0]    irq_pend_q,
    output logic                irq_valid_q,
    output logic      [4:0]     irq_num_q,
    output logic      [23:0]    vector_q,
    output logic                wake_q,
    output logic                evt_return_q
);
    logic [18:0]    pend_d;
    logic [18:0]    wake_ok;
    logic [18:0]    served;
    logic           valid_d;
    logic [4:0]     num_d;
    logic [23:0]    vec_d;
    logic           wake_d;
    logic           ret_d;
    logic           from_evt_q;
    logic           from_evt_d;
    logic [4:0]     irq_num_d;
    logic [23:0]    vector_d;
    ivwm_state_type st_q;
    ivwm_state_type st_d;

    always_comb begin
        pend_d = '0;
        pend_d[`IVWM_IRQ_TOP]   = tim2_ovf_req | tim4_ovf_req;
        pend_d[`IVWM_IRQ_FLASH] = |flash_req;
        pend_d[`IVWM_IRQ_DMA01] = |dma01_req;
        pend_d[`IVWM_IRQ_DMA23] = |dma23_req;
        pend_d[`IVWM_IRQ_RTC]   = |rtc_req;
        pend_d[`IVWM_IRQ_VDET]  = voltage_detector_request;
        pend_d[`IVWM_IRQ_PORTB] = port_b_pin_request;
        pend_d[`IVWM_IRQ_PORTD] = port_d_pin_request;
        pend_d[`IVWM_IRQ_PIN0 +: 8] = pin_req;
        pend_d[`IVWM_IRQ_RSVD]  = 1'b0;
        pend_d[`IVWM_IRQ_CLK]   = clock_security_request;
        pend_d[`IVWM_IRQ_ADC]   = |adc_req;
    end

    ivwm_wake_sel u_wake (
        .pend    (irq_pend_q),
        .mode    (core_mode),
        .wake_ok (wake_ok)
    );

    // Only enabled requests are served
    assign served = irq_pend_q & irq_enable;

    // Lowest enabled IRQ number wins
    always_comb begin
        num_d = 5'h00;
        for (int i = `IVWM_NUM_IRQ - 1; i >= 0; i--) begin
            if (served[i]) begin
                num_d = 5'(i);
            end
        end
        vec_d    = `IVWM_VEC_BASE + {17'h00000, num_d, 2'b00};
        valid_d    = irq_valid_q;
        st_d       = st_q;
        from_evt_d = from_evt_q;
        ret_d      = 1'b0;
        irq_num_d  = irq_num_q;
        vector_d   = vector_q;
        wake_d     = (core_mode != IVWM_RUN) && (|(wake_ok & irq_enable));
        case (st_q)
            IVWM_IDLE: begin
                // Number and vector follow only while idle
                irq_num_d = num_d;
                vector_d  = vec_d;
                if (|served && (core_mode == IVWM_RUN || |(wake_ok & irq_enable))) begin
                    st_d       = IVWM_SERVE;
                    valid_d    = 1'b1;
                    from_evt_d = (core_mode == IVWM_WAIT_FOR_EVENT_MODE);
                end
            end
            IVWM_SERVE: begin
                if (irq_done) begin
                    st_d    = IVWM_BACK;
                    valid_d = 1'b0;
                end
            end
            IVWM_BACK: begin
                st_d     = IVWM_IDLE;
                ret_d      = from_evt_q;
                from_evt_d = 1'b0;
            end
            default: begin
                st_d    = IVWM_IDLE;
                valid_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pend_q   <= '0;
            irq_valid_q  <= 1'b0;
            irq_num_q    <= 5'h00;
            vector_q     <= `IVWM_VEC_RESET;
            wake_q       <= 1'b0;
            evt_return_q <= 1'b0;
            from_evt_q   <= 1'b0;
            st_q         <= IVWM_IDLE;
        end else begin
            irq_pend_q   <= pend_d;
            irq_valid_q  <= valid_d;
            irq_num_q    <= irq_num_d;
            vector_q     <= vector_d;
            wake_q       <= wake_d;
            evt_return_q <= ret_d;
            from_evt_q   <= from_evt_d;
            st_q         <= st_d;
        end
    end

    top_no_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode != IVWM_RUN && irq_pend_q == 19'h00001) |=> !wake_q)
        else $error("Top-level request woke the core");
    flash_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_HALT && (irq_pend_q & irq_enable) == 19'h00002) |=> !wake_q)
        else $error("Flash request woke core from halt");
    dma_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_WAIT_FOR_INTERRUPT_MODE && (irq_pend_q[2] & irq_enable[2])) |=> wake_q)
        else $error("DMA request failed to wake from wait");
    dma23_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_ACTIVE_HALT && (irq_pend_q & irq_enable) == 19'h00008) |=> !wake_q)
        else $error("DMA 2/3 request woke core from halt");
    rtc_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_HALT && irq_pend_q[4] && irq_enable[4]) |=> wake_q)
        else $error("Clock alarm failed to wake from halt");
    portb_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_ACTIVE_HALT && irq_pend_q[6] && irq_enable[6]) |=> wake_q)
        else $error("Port B request failed to wake");
    portd_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_WAIT_FOR_EVENT_MODE && irq_pend_q[7] && irq_enable[7]) |=> wake_q)
        else $error("Port D request failed to wake");
    adc_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_HALT && irq_pend_q[18] && irq_enable[18]) |=> wake_q)
        else $error("Converter request failed to wake");
    top_or_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tim2_ovf_req || tim4_ovf_req) |=> irq_pend_q[0])
        else $error("Top-level request not formed from timers");
    evt_return_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == IVWM_SERVE && from_evt_q && irq_done) |=> ##1 evt_return_q)
        else $error("No return to wait-for-event mode");
    vector_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(irq_valid_q) |-> vector_q == `IVWM_VEC_BASE + {17'h00000, irq_num_q, 2'b00} && !irq_pend_q[16])
        else $error("Vector does not match IRQ number");
    pin_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_HALT && |(irq_pend_q[15:8] & irq_enable[15:8])) |=> wake_q)
        else $error("Pin line failed to wake");

    top_no_serve_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode != IVWM_RUN && st_q == IVWM_IDLE && (irq_pend_q & irq_enable) == 19'h00001) |=> !irq_valid_q)
        else $error("Top-level request served in low-power mode");
    flash_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_WAIT_FOR_INTERRUPT_MODE && irq_pend_q[1] && irq_enable[1]) |=> wake_q)
        else $error("Flash request failed to wake from wait");
    flash_active_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_ACTIVE_HALT && (irq_pend_q & irq_enable) == 19'h00002) |=> !wake_q)
        else $error("Flash request woke core from active halt");
    dma01_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_HALT && (irq_pend_q & irq_enable) == 19'h00004) |=> !wake_q)
        else $error("DMA 0/1 request woke core from halt");
    dma23_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_WAIT_FOR_EVENT_MODE && irq_pend_q[3] && irq_enable[3]) |=> wake_q)
        else $error("DMA 2/3 request failed to wake from wait");
    rtc_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_WAIT_FOR_INTERRUPT_MODE && irq_pend_q[4] && irq_enable[4]) |=> wake_q)
        else $error("Clock alarm failed to wake from wait");
    portb_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_HALT && irq_pend_q[6] && irq_enable[6]) |=> wake_q)
        else $error("Port B request failed to wake from halt");
    portd_active_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_ACTIVE_HALT && irq_pend_q[7] && irq_enable[7]) |=> wake_q)
        else $error("Port D request failed to wake from active halt");
    adc_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_WAIT_FOR_EVENT_MODE && irq_pend_q[18] && irq_enable[18]) |=> wake_q)
        else $error("Converter request failed to wake from wait");
    top_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!tim2_ovf_req && !tim4_ovf_req) |=> !irq_pend_q[0])
        else $error("Top-level request without timer request");
    evt_enabled_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_WAIT_FOR_EVENT_MODE && st_q == IVWM_IDLE
            && (irq_pend_q & irq_enable) == 19'h00000) |=> !irq_valid_q)
        else $error("Disabled request served in wait-for-event mode");
    return_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        evt_return_q |=> !evt_return_q)
        else $error("Return pulse longer than one cycle");
    vector_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q != IVWM_IDLE) |=> ($stable(vector_q) && $stable(irq_num_q)))
        else $error("Vector changed while serving");
    pin_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_WAIT_FOR_EVENT_MODE && |(irq_pend_q[15:8] & irq_enable[15:8])) |=> wake_q)
        else $error("Pin line failed to wake from wait");
    pin_active_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_mode == IVWM_ACTIVE_HALT && |(irq_pend_q[15:8] & irq_enable[15:8])) |=> wake_q)
        else $error("Pin line failed to wake from active halt");

    serve_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq_valid_q));
    evt_c: cover property (@(posedge ref_clk) disable iff (!rst_n) evt_return_q);
    halt_wake_c: cover property (@(posedge ref_clk) disable iff (!rst_n) core_mode == IVWM_HALT ##1 wake_q);
    active_wake_c: cover property (@(posedge ref_clk) disable iff (!rst_n) core_mode == IVWM_ACTIVE_HALT ##1 wake_q);
    pin_serve_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq_valid_q) && irq_num_q == 5'h08);
endmodule

// >>> bench/ivwm_core_model.sv
module ivwm_core_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       irq_valid_q,
    input  wire logic [2:0] delay,
    output logic            irq_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    // Handler runs delay+1 cycles, then reports done until service drops
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            irq_done <= 1'b0;
        end else if (irq_valid_q) begin
            cnt_q <= cnt_q + 4'h1;
            irq_done <= (cnt_q >= {1'b0, delay});
        end else begin
            cnt_q <= 4'h0;
            irq_done <= 1'b0;
        end
    end
endmodule

// >>> bench/irq_vector_wakeup_map_test.sv
module irq_vector_wakeup_map_test import ivwm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [18:0] HALT_WAKE = 19'h4fff0;
    localparam logic [18:0] WAIT_WAKE = 19'h6fffe;
    logic ref_clk = 0, rst_n = 0, tim2_ovf_req = 0, tim4_ovf_req = 0, irq_done;
    logic voltage_detector_request = 0, port_b_pin_request = 0, port_d_pin_request = 0, clock_security_request = 0;
    logic [1:0] flash_req = '0;
    logic [3:0] dma01_req = '0, dma23_req = '0;
    logic [4:0] rtc_req = '0;
    logic [7:0] pin_req = '0;
    logic [2:0] adc_req = '0, delay = '0;
    logic [18:0] irq_enable = '0, irq_pend_q;
    ivwm_mode_type core_mode = IVWM_RUN;
    logic irq_valid_q, wake_q, evt_return_q, prev_valid;
    logic [4:0] irq_num_q;
    logic [23:0] vector_q;
    logic [28:0] exp_q[$];
    int err_count = 0, n_tests = 0, ret_exp = 0, ret_seen = 0, n, a, b;
    ivwm_mode_type modes[5] = '{IVWM_RUN, IVWM_HALT, IVWM_ACTIVE_HALT,
                                IVWM_WAIT_FOR_INTERRUPT_MODE, IVWM_WAIT_FOR_EVENT_MODE};

    ivwm_top ivwm_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .tim2_ovf_req(tim2_ovf_req), .tim4_ovf_req(tim4_ovf_req),
        .flash_req(flash_req), .dma01_req(dma01_req), .dma23_req(dma23_req), .rtc_req(rtc_req),
        .voltage_detector_request(voltage_detector_request), .port_b_pin_request(port_b_pin_request),
        .port_d_pin_request(port_d_pin_request), .pin_req(pin_req), .clock_security_request(clock_security_request),
        .adc_req(adc_req), .irq_enable(irq_enable), .core_mode(core_mode), .irq_done(irq_done),
        .irq_pend_q(irq_pend_q), .irq_valid_q(irq_valid_q), .irq_num_q(irq_num_q), .vector_q(vector_q),
        .wake_q(wake_q), .evt_return_q(evt_return_q));
    ivwm_core_model ivwm_core_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .irq_valid_q(irq_valid_q),
        .delay(delay), .irq_done(irq_done));

    always #5 ref_clk = ~ref_clk;

    task automatic check(input logic [28:0] seen, input logic [28:0] want);
        n_tests++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic set_src(input int s);
        int unsigned r;
        r = $urandom;
        case (s)
            0: if (r[0]) tim2_ovf_req = 1'b1; else tim4_ovf_req = 1'b1;
            1: flash_req[r % 2] = 1'b1;
            2: dma01_req[r % 4] = 1'b1;
            3: dma23_req[r % 4] = 1'b1;
            4: rtc_req[r % 5] = 1'b1;
            5: voltage_detector_request = 1'b1;
            6: port_b_pin_request = 1'b1;
            7: port_d_pin_request = 1'b1;
            17: clock_security_request = 1'b1;
            18: adc_req[r % 3] = 1'b1;
            default: pin_req[s - 8] = 1'b1;
        endcase
    endtask

    task automatic run_one(input ivwm_mode_type m, input int s, input int t, input logic en);
        logic wk, serve;
        int i, w;
        @(negedge ref_clk);
        core_mode = m;
        irq_enable = en ? 19'h7ffff : 19'h00000;
        delay = 3'($urandom % 5);
        set_src(s);
        w = s;
        if (t >= 0) begin
            set_src(t);
            w = t < s ? t : s;
        end
        wk = en && ((m == IVWM_HALT || m == IVWM_ACTIVE_HALT) ? HALT_WAKE[s] : (m != IVWM_RUN && WAIT_WAKE[s]));
        serve = en && (m == IVWM_RUN || wk);
        if (serve) exp_q.push_back({5'(w), 24'h008008 + 24'(4 * w)});
        if (serve && m == IVWM_WAIT_FOR_EVENT_MODE) ret_exp++;
        repeat (2) @(posedge ref_clk);
        #1 check(29'(wake_q), 29'(wk));
        check(29'(irq_pend_q), 29'((19'h00001 << s) | (t >= 0 ? 19'h00001 << t : 19'h00000)));
        @(negedge ref_clk);
        tim2_ovf_req = 0; tim4_ovf_req = 0; flash_req = '0; dma01_req = '0; dma23_req = '0; rtc_req = '0;
        voltage_detector_request = 0; port_b_pin_request = 0; port_d_pin_request = 0; pin_req = '0;
        clock_security_request = 0; adc_req = '0;
        for (i = 0; i < 20 && irq_valid_q !== 1'b0; i++) @(negedge ref_clk);
        if (i == 20) begin
            err_count++;
            complete_run();
        end
        repeat (3) @(negedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        #1;
        if (irq_valid_q === 1'b1 && prev_valid !== 1'b1) begin
            if (exp_q.size() == 0) check({irq_num_q, vector_q}, '1);
            else check({irq_num_q, vector_q}, exp_q.pop_front());
        end
        prev_valid = irq_valid_q;
        if (evt_return_q === 1'b1) ret_seen++;
        check(29'(irq_pend_q[16]), 29'h0);
    end

    initial begin
        void'($urandom(58307));
        repeat (3) @(negedge ref_clk);
        check(29'(vector_q), 29'h008000);
        rst_n = 1'b1;
        foreach (modes[k]) for (n = 0; n < 19; n++) if (n != 16) run_one(modes[k], n, -1, 1'b1);
        for (n = 0; n < 19; n++) if (n != 16) run_one(IVWM_WAIT_FOR_EVENT_MODE, n, -1, 1'b0);
        repeat (20) begin
            a = $urandom % 19;
            b = $urandom % 19;
            if (a != 16 && b != 16) run_one(IVWM_RUN, a, b, 1'b1);
        end
        check(29'(exp_q.size()), 29'h0);
        check(29'(ret_seen), 29'(ret_exp));
        complete_run();
    end
endmodule
